// *** core/tdp_translation_buffer.sv ***
module tdp_translation_buffer
  import tdp_pkg::*;
#(
  parameter int ENTRIES = tdp_pkg::NUM_ENTRIES,
  parameter int IDX_W   = $clog2(ENTRIES)
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic [tdp_pkg::ADDR_W-1:0]  pageSizeMaskStaging,
  input  wire logic [tdp_pkg::ADDR_W-1:0]  entryHighStaging,
  input  wire logic [tdp_pkg::ADDR_W-1:0]  entryLowEvenStaging,
  input  wire logic [tdp_pkg::ADDR_W-1:0]  entryLowOddStaging,
  input  wire logic                        smallPageEnable,
  input  wire logic                        inhibitExcEnable,
  input  wire logic                        writeIndexedEntryInstr,
  input  wire logic                        writeRandomEntryInstr,
  input  wire logic [IDX_W-1:0]            indexSelect,
  input  wire logic [IDX_W-1:0]            randomSelect,
  input  wire logic                        accessValid,
  input  wire tdp_pkg::tdp_kind_e          accessKind,
  input  wire logic [tdp_pkg::ADDR_W-1:0]  accessVaddr,
  output logic                             rspValid,
  output logic                             rspHit,
  output logic                             rspMiss,
  output logic [tdp_pkg::ADDR_W-1:0]       rspPaddr,
  output logic [tdp_pkg::CATTR_W-1:0]      rspCacheAttr,
  output logic                             rspExcReadInhibit,
  output logic                             rspExcExecInhibit,
  output logic                             rspExcInvalid,
  output logic                             rspExcModified,
  output logic                             rspAbort
);
  import tdp_pkg::*;

  tdp_entry_s             entry_ff  [ENTRIES];
  tdp_entry_s             nxt_entry [ENTRIES];
  tdp_entry_s             newEntry;
  logic                   wrEn;
  logic [IDX_W-1:0]       wrIdx;
  logic [ENTRIES-1:0]     entryMatch;
  logic                   anyHit;
  logic [IDX_W-1:0]       hitIdx;
  tdp_entry_s             hitEntry;
  logic [SEL_W-1:0]       selBit;
  logic                   oddSel;
  logic [ADDRESS_SPACE_ID_W-1:0]      curAsid;

  logic                   rspValid_ff;
  logic                   rspHit_ff;
  logic                   rspMiss_ff;
  logic [ADDR_W-1:0]      rspPaddr_ff;
  logic [CATTR_W-1:0]     rspCacheAttr_ff;
  logic [3:0]             rspExc_ff;
  logic                   nxt_rspValid;
  logic                   nxt_rspHit;
  logic                   nxt_rspMiss;
  logic [ADDR_W-1:0]      nxt_rspPaddr;
  logic [CATTR_W-1:0]     nxt_rspCacheAttr;
  logic [3:0]             nxt_rspExc;

  tdp_half_if hif ();

  // Select bit is bit 10, raised two per set mask pair from the bottom (pair 0 always in normal mode)
  function automatic logic [SEL_W-1:0] selBitOf(input logic [MASK_W-1:0] m,
                                                 input logic            smallMode);
    logic [SEL_W-1:0] b;
    b = SEL_BIT_SMALL;
    for (int p = 0; p < MASK_W / 2; p++) begin
      if ((m[2*p+1] || (p == 0 && !smallMode)) && b == SEL_W'(SEL_BIT_SMALL + 2 * p)) begin
        b = SEL_W'(b + 2);
      end
    end
    return b;
  endfunction

  // Entry image built from the staging words
  always_comb begin
    newEntry.written                  = 1'b1;
    newEntry.pageSizeMask             = pageSizeMaskStaging[PM_LSB +: MASK_W];
    newEntry.virtualPagePairNumber    = entryHighStaging[HI_VIRTUAL_PAGE_PAIR_NUMBER_LSB +: VIRTUAL_PAGE_PAIR_NUMBER_W];
    newEntry.virtualPagePairExtension = entryHighStaging[HI_VPNX_LSB +: VPNX_W];
    newEntry.addressSpaceId           = entryHighStaging[HI_ADDRESS_SPACE_ID_LSB +: ADDRESS_SPACE_ID_W];
    newEntry.isGlobal = entryLowEvenStaging[LO_G_BIT] & entryLowOddStaging[LO_G_BIT];
    newEntry.even.pfn         = entryLowEvenStaging[LO_PFN_LSB +: PFN_W];
    newEntry.even.cattr       = entryLowEvenStaging[LO_C_LSB +: CATTR_W];
    newEntry.even.readInhibit = entryLowEvenStaging[LO_RI_BIT];
    newEntry.even.execInhibit = entryLowEvenStaging[LO_XI_BIT];
    newEntry.even.writeEnable = entryLowEvenStaging[LO_WE_BIT];
    newEntry.even.valid       = entryLowEvenStaging[LO_V_BIT];
    newEntry.odd.pfn          = entryLowOddStaging[LO_PFN_LSB +: PFN_W];
    newEntry.odd.cattr        = entryLowOddStaging[LO_C_LSB +: CATTR_W];
    newEntry.odd.readInhibit  = entryLowOddStaging[LO_RI_BIT];
    newEntry.odd.execInhibit  = entryLowOddStaging[LO_XI_BIT];
    newEntry.odd.writeEnable  = entryLowOddStaging[LO_WE_BIT];
    newEntry.odd.valid        = entryLowOddStaging[LO_V_BIT];
  end

  // Entry write, indexed form wins over random
  always_comb begin
    wrEn  = writeIndexedEntryInstr || writeRandomEntryInstr;
    wrIdx = writeIndexedEntryInstr ? indexSelect : randomSelect;
    for (int i = 0; i < ENTRIES; i++) begin
      nxt_entry[i] = entry_ff[i];
    end
    if (wrEn) begin
      nxt_entry[wrIdx] = newEntry;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ENTRIES; i++) begin
        entry_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < ENTRIES; i++) begin
        entry_ff[i] <= nxt_entry[i];
      end
    end
  end

  // Tag compare per entry under its own page mask
  assign curAsid = entryHighStaging[HI_ADDRESS_SPACE_ID_LSB +: ADDRESS_SPACE_ID_W];

  generate
    for (genvar g = 0; g < ENTRIES; g++) begin : gMatch
      logic [CMP_W-1:0] ignore;
      logic [CMP_W-1:0] diff;
      always_comb begin
        ignore = {3'b000, entry_ff[g].pageSizeMask};
        if (!smallPageEnable) begin
          ignore[VPNX_W-1:0] = {VPNX_W{1'b1}};
        end
        diff = accessVaddr[ADDR_W-1:SMALL_SHIFT+1]
               ^ {entry_ff[g].virtualPagePairNumber, entry_ff[g].virtualPagePairExtension};
        entryMatch[g] = entry_ff[g].written && ((diff & ~ignore) == '0)
                        && (entry_ff[g].isGlobal
                            || entry_ff[g].addressSpaceId == curAsid);
      end
    end
  endgenerate

  // Lowest matching entry, then its even or odd half
  always_comb begin
    anyHit = 1'b0;
    hitIdx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (entryMatch[i]) begin
        anyHit = 1'b1;
        hitIdx = IDX_W'(i);
      end
    end
    hitEntry         = entry_ff[hitIdx];
    selBit           = selBitOf(hitEntry.pageSizeMask, smallPageEnable);
    oddSel           = accessVaddr[selBit];
    hif.half         = oddSel ? hitEntry.odd : hitEntry.even;
    hif.vaddr        = accessVaddr;
    hif.selBit       = selBit;
    hif.smallPage    = smallPageEnable;
    hif.inhibitExcEn = inhibitExcEnable;
    hif.kind         = accessKind;
  end

  tdp_half_check uCheck (
    .hc (hif.chk)
  );

  // Response for each taken access, one cycle later
  always_comb begin
    nxt_rspValid     = accessValid;
    nxt_rspHit       = accessValid && anyHit;
    nxt_rspMiss      = accessValid && !anyHit;
    nxt_rspPaddr     = anyHit ? hif.paddr : '0;
    nxt_rspCacheAttr = anyHit ? hif.cacheAttr : CA_UNCACHED;
    nxt_rspExc       = {4{accessValid && anyHit}}
                       & {hif.excModified, hif.excInvalid,
                          hif.excExecInhibit, hif.excReadInhibit};
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rspValid_ff     <= 1'b0;
      rspHit_ff       <= 1'b0;
      rspMiss_ff      <= 1'b0;
      rspPaddr_ff     <= '0;
      rspCacheAttr_ff <= CA_UNCACHED;
      rspExc_ff       <= 4'h0;
    end else begin
      rspValid_ff     <= nxt_rspValid;
      rspHit_ff       <= nxt_rspHit;
      rspMiss_ff      <= nxt_rspMiss;
      rspPaddr_ff     <= nxt_rspPaddr;
      rspCacheAttr_ff <= nxt_rspCacheAttr;
      rspExc_ff       <= nxt_rspExc;
    end
  end

  // Outputs; abort tells the pipeline to drop the access
  assign rspValid          = rspValid_ff;
  assign rspHit            = rspHit_ff;
  assign rspMiss           = rspMiss_ff;
  assign rspPaddr          = rspPaddr_ff;
  assign rspCacheAttr      = rspCacheAttr_ff;
  assign rspExcReadInhibit = rspExc_ff[0];
  assign rspExcExecInhibit = rspExc_ff[1];
  assign rspExcInvalid     = rspExc_ff[2];
  assign rspExcModified    = rspExc_ff[3];
  assign rspAbort          = rspMiss_ff || (rspExc_ff != 4'h0);
endmodule

// *** core/tdp_pkg.sv ***
package tdp_pkg;
  // Widths of the translated address and the entry fields
  localparam int ADDR_W  = 32;
  localparam int PFN_W   = 20;
  localparam int ADDRESS_SPACE_ID_W  = 8;
  localparam int MASK_W  = 18;
  localparam int VIRTUAL_PAGE_PAIR_NUMBER_W  = 19;
  localparam int VPNX_W  = 2;
  localparam int CATTR_W = 3;
  localparam int SEL_W   = 5;
  localparam int CMP_W   = VIRTUAL_PAGE_PAIR_NUMBER_W + VPNX_W;

  // Field positions in the low staging words
  localparam int LO_G_BIT   = 0;
  localparam int LO_V_BIT   = 1;
  localparam int LO_WE_BIT  = 2;
  localparam int LO_C_LSB   = 3;
  localparam int LO_PFN_LSB = 6;
  localparam int LO_XI_BIT  = 30;
  localparam int LO_RI_BIT  = 31;

  // Field positions in the high staging word and the page mask word
  localparam int HI_ADDRESS_SPACE_ID_LSB = 0;
  localparam int HI_VPNX_LSB = 11;
  localparam int HI_VIRTUAL_PAGE_PAIR_NUMBER_LSB = 13;
  localparam int PM_LSB      = 11;

  // Page offset widths and the lowest even/odd select bit
  localparam int               NORMAL_SHIFT  = 12;
  localparam int               SMALL_SHIFT   = 10;
  localparam logic [SEL_W-1:0] SEL_BIT_SMALL = 5'h0A;

  // Cacheability codes
  localparam logic [CATTR_W-1:0] CA_WT_NOALLOC = 3'h0;
  localparam logic [CATTR_W-1:0] CA_WT_ALLOC   = 3'h1;
  localparam logic [CATTR_W-1:0] CA_UNCACHED   = 3'h2;
  localparam logic [CATTR_W-1:0] CA_WB_ALLOC   = 3'h3;

  // Default number of entry pairs
  localparam int NUM_ENTRIES = 16;

  typedef enum logic [1:0] {
    TDP_FETCH = 2'h0,
    TDP_LOAD  = 2'h1,
    TDP_STORE = 2'h2
  } tdp_kind_e;

  typedef struct packed {
    logic [PFN_W-1:0]   pfn;
    logic [CATTR_W-1:0] cattr;
    logic               readInhibit;
    logic               execInhibit;
    logic               writeEnable;
    logic               valid;
  } tdp_half_s;

  typedef struct packed {
    logic                 written;
    logic [MASK_W-1:0]    pageSizeMask;
    logic [VIRTUAL_PAGE_PAIR_NUMBER_W-1:0]    virtualPagePairNumber;
    logic [VPNX_W-1:0]    virtualPagePairExtension;
    logic [ADDRESS_SPACE_ID_W-1:0]    addressSpaceId;
    logic                 isGlobal;
    tdp_half_s            even;
    tdp_half_s            odd;
  } tdp_entry_s;
endpackage

// *** core/tdp_half_if.sv ***
interface tdp_half_if;
  import tdp_pkg::*;
  tdp_half_s             half;
  logic [ADDR_W-1:0]     vaddr;
  logic [SEL_W-1:0]      selBit;
  logic                  smallPage;
  logic                  inhibitExcEn;
  tdp_kind_e             kind;
  logic [ADDR_W-1:0]     paddr;
  logic [CATTR_W-1:0]    cacheAttr;
  logic                  excReadInhibit;
  logic                  excExecInhibit;
  logic                  excInvalid;
  logic                  excModified;

  modport sel (output half, vaddr, selBit, smallPage, inhibitExcEn, kind,
               input paddr, cacheAttr, excReadInhibit, excExecInhibit, excInvalid,
               excModified);
  modport chk (input half, vaddr, selBit, smallPage, inhibitExcEn, kind,
               output paddr, cacheAttr, excReadInhibit, excExecInhibit, excInvalid,
               excModified);
endinterface

// *** core/tdp_half_check.sv ***
module tdp_half_check (
  tdp_half_if.chk hc
);
  import tdp_pkg::*;

  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] offMask;
  logic              inhibited;

  // Frame placement and untranslated offset merge
  always_comb begin
    if (hc.smallPage) begin
      base = {2'b00, hc.half.pfn, {SMALL_SHIFT{1'b0}}};
    end else begin
      base = {hc.half.pfn, {NORMAL_SHIFT{1'b0}}};
    end
    offMask  = (32'h1 << hc.selBit) - 32'h1;
    hc.paddr = (base & ~offMask) | (hc.vaddr & offMask);
  end

  // Cacheability decode with aliased codes folded
  always_comb begin
    case (hc.half.cattr)
      3'h4, 3'h5, 3'h6: hc.cacheAttr = CA_WB_ALLOC;
      3'h7:             hc.cacheAttr = CA_UNCACHED;
      default:          hc.cacheAttr = hc.half.cattr;
    endcase
  end

  // Permission checks, inhibits first, then valid, then write enable
  always_comb begin
    hc.excReadInhibit = hc.inhibitExcEn && hc.half.readInhibit
                        && (hc.kind == TDP_LOAD);
    hc.excExecInhibit = hc.inhibitExcEn && hc.half.execInhibit
                        && (hc.kind == TDP_FETCH);
    inhibited         = hc.excReadInhibit || hc.excExecInhibit;
    hc.excInvalid     = !inhibited && !hc.half.valid;
    hc.excModified    = !inhibited && hc.half.valid && (hc.kind == TDP_STORE)
                        && !hc.half.writeEnable;
  end
endmodule

// *** verification/tdp_monitor.sv ***
module tdp_monitor
  import tdp_pkg::*;
(
  input wire logic                        core_clk,
  input wire logic                        rst,
  input wire logic                        smallPageEnable,
  input wire logic                        inhibitExcEnable,
  input wire logic                        accessValid,
  input wire tdp_pkg::tdp_kind_e          accessKind,
  input wire logic [tdp_pkg::ADDR_W-1:0]  accessVaddr,
  input wire logic                        rspValid,
  input wire logic                        rspHit,
  input wire logic                        rspMiss,
  input wire logic [tdp_pkg::ADDR_W-1:0]  rspPaddr,
  input wire logic [tdp_pkg::CATTR_W-1:0] rspCacheAttr,
  input wire logic                        rspExcReadInhibit,
  input wire logic                        rspExcExecInhibit,
  input wire logic                        rspExcInvalid,
  input wire logic                        rspExcModified,
  input wire logic                        rspAbort
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ADDR_W-1:0] va_ff;
  logic [1:0]        kind_ff;
  logic              small_ff;
  logic              en_ff;

  // Access qualifiers held for the response cycle
  always_ff @(posedge core_clk) begin
    {va_ff, kind_ff, small_ff, en_ff} <=
      {accessVaddr, accessKind, smallPageEnable, inhibitExcEnable};
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Response timing and exception summary
  chk_rsp_latency: assert property (accessValid |=> rspValid)
    else $error("response missing one cycle after access");
  chk_rsp_spurious: assert property (!accessValid |=> !rspValid)
    else $error("response without access");
  chk_abort_sum: assert property (rspValid |-> rspAbort == (rspMiss | rspExcReadInhibit
    | rspExcExecInhibit | rspExcInvalid | rspExcModified))
    else $error("abort does not follow miss and exceptions");
  chk_one_exc: assert property (rspValid |-> $onehot0({rspMiss, rspExcReadInhibit,
    rspExcExecInhibit, rspExcInvalid, rspExcModified}))
    else $error("more than one fault reported");
  chk_hit_excl: assert property (rspHit |-> rspValid && !rspMiss)
    else $error("hit reported with miss or without response");
  // Read inhibit, execute inhibit and modified exceptions tied to their access kinds
  chk_ri_cause: assert property (rspExcReadInhibit |-> kind_ff == TDP_LOAD && en_ff)
    else $error("read inhibit without enabled load");
  chk_xi_cause: assert property (rspExcExecInhibit |-> kind_ff == TDP_FETCH && en_ff)
    else $error("execute inhibit without enabled fetch");
  chk_mod_cause: assert property (rspExcModified |-> kind_ff == TDP_STORE)
    else $error("modified fault on non-store");
  // Address forming and attribute folding
  chk_small_top: assert property (rspValid && rspHit && small_ff |->
    rspPaddr[31:30] == 2'h0 && rspPaddr[9:0] == va_ff[9:0])
    else $error("small page address malformed");
  chk_normal_off: assert property (rspValid && rspHit && !small_ff |->
    rspPaddr[11:0] == va_ff[11:0])
    else $error("page offset not passed through");
  chk_cattr_fold: assert property (rspValid && rspHit |-> !rspCacheAttr[2])
    else $error("cacheability code not folded");

  cover property (rspValid && rspHit && !rspAbort);
  cover property (rspValid && rspExcModified);
  cover property (rspValid && rspExcReadInhibit);
endmodule

bind tdp_translation_buffer tdp_monitor uMon (.core_clk(core_clk), .rst(rst),
  .smallPageEnable(smallPageEnable), .inhibitExcEnable(inhibitExcEnable),
  .accessValid(accessValid), .accessKind(accessKind), .accessVaddr(accessVaddr),
  .rspValid(rspValid), .rspHit(rspHit), .rspMiss(rspMiss), .rspPaddr(rspPaddr),
  .rspCacheAttr(rspCacheAttr), .rspExcReadInhibit(rspExcReadInhibit),
  .rspExcExecInhibit(rspExcExecInhibit), .rspExcInvalid(rspExcInvalid),
  .rspExcModified(rspExcModified), .rspAbort(rspAbort));

// *** verification/tdp_pipe_model.sv ***
module tdp_pipe_model (
  input  wire logic  core_clk,
  output logic [31:0] pageSizeMaskStaging,
  output logic [31:0] entryHighStaging,
  output logic [31:0] entryLowEvenStaging,
  output logic [31:0] entryLowOddStaging,
  output logic        writeIndexedEntryInstr,
  output logic        writeRandomEntryInstr,
  output logic [3:0]  indexSelect,
  output logic [3:0]  randomSelect
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle coprocessor state at time zero
  initial begin
    {pageSizeMaskStaging, entryHighStaging, entryLowEvenStaging, entryLowOddStaging} = '0;
    {writeIndexedEntryInstr, writeRandomEntryInstr, indexSelect, randomSelect} = '0;
  end

  // Staging words settle a full cycle before the write strobe
  task automatic put_entry(input logic rnd, input logic [3:0] idx,
                           input logic [31:0] pm, hi, lo0, lo1);
    @(posedge core_clk);
    pageSizeMaskStaging <= pm;
    entryHighStaging <= hi;
    entryLowEvenStaging <= lo0;
    entryLowOddStaging <= lo1;
    @(posedge core_clk);
    writeIndexedEntryInstr <= !rnd;
    writeRandomEntryInstr <= rnd;
    indexSelect <= idx;
    randomSelect <= idx;
    @(posedge core_clk);
    writeIndexedEntryInstr <= 1'h0;
    writeRandomEntryInstr <= 1'h0;
  endtask

  // Current identifier change without an entry write
  task automatic set_high(input logic [31:0] hi);
    @(posedge core_clk);
    entryHighStaging <= hi;
  endtask
endmodule

// *** verification/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tdp_pkg::*;
  logic        core_clk, rst, smallPageEnable, inhibitExcEnable, accessValid;
  tdp_kind_e   accessKind;
  logic [31:0] accessVaddr, pmS, hiS, loE, loO, rspPaddr;
  logic [3:0]  idxS, rndS;
  logic        wrI, wrR, rspValid, rspHit, rspMiss, rspAbort;
  logic        rspExcReadInhibit, rspExcExecInhibit, rspExcInvalid, rspExcModified;
  logic [2:0]  rspCacheAttr;
  wire  [6:0]  flags = {rspValid, rspAbort, rspMiss, rspExcReadInhibit, rspExcExecInhibit,
                        rspExcInvalid, rspExcModified};
  int          nMismatch = 0;
  int          testsRun = 0;
  int          cycles = 0;

  tdp_pipe_model uPipe (.core_clk(core_clk), .pageSizeMaskStaging(pmS),
    .entryHighStaging(hiS), .entryLowEvenStaging(loE), .entryLowOddStaging(loO),
    .writeIndexedEntryInstr(wrI), .writeRandomEntryInstr(wrR), .indexSelect(idxS),
    .randomSelect(rndS));
  tdp_translation_buffer uut (.core_clk(core_clk), .rst(rst), .pageSizeMaskStaging(pmS),
    .entryHighStaging(hiS), .entryLowEvenStaging(loE), .entryLowOddStaging(loO),
    .smallPageEnable(smallPageEnable), .inhibitExcEnable(inhibitExcEnable),
    .writeIndexedEntryInstr(wrI), .writeRandomEntryInstr(wrR), .indexSelect(idxS),
    .randomSelect(rndS), .accessValid(accessValid), .accessKind(accessKind),
    .accessVaddr(accessVaddr), .rspValid(rspValid), .rspHit(rspHit), .rspMiss(rspMiss),
    .rspPaddr(rspPaddr), .rspCacheAttr(rspCacheAttr), .rspExcReadInhibit(rspExcReadInhibit),
    .rspExcExecInhibit(rspExcExecInhibit), .rspExcInvalid(rspExcInvalid),
    .rspExcModified(rspExcModified), .rspAbort(rspAbort));

  // Core clock and hang guard
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      nMismatch++;
      report_and_stop();
    end
  end

  // Staging word builders
  function automatic logic [31:0] hiw(input logic [31:0] va, input logic [7:0] id);
    return {va[31:11], 3'h0, id};
  endfunction
  function automatic logic [31:0] low(input logic [1:0] rx, input logic [19:0] pfn,
                                      input logic [2:0] c, input logic [2:0] wvg);
    return {rx, 4'h0, pfn, c, wvg};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nMismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One lookup, judged in the response cycle
  task automatic acc(input tdp_kind_e k, input logic [31:0] va, input logic en, sp);
    @(posedge core_clk);
    accessValid <= 1'h1;
    accessKind <= k;
    accessVaddr <= va;
    inhibitExcEnable <= en;
    smallPageEnable <= sp;
    @(posedge core_clk);
    accessValid <= 1'h0;
    #1;
  endtask

  // Normal page pair, write enable and identifier
  task automatic t_pair();
    uPipe.put_entry(1'h0, 4'h3, 32'h0, hiw(32'h0040_2000, 8'h05),
                    low(2'h0, 20'hABCDE, 3'h4, 3'h3), low(2'h0, 20'h12345, 3'h7, 3'h6));
    acc(TDP_LOAD, 32'h0040_2ABC, 1'h1, 1'h0);
    chk(rspPaddr, 32'hABCD_EABC);
    chk(flags, 7'h40);
    chk(rspHit, 1'h1);
    acc(TDP_STORE, 32'h0040_2004, 1'h1, 1'h0);
    chk(flags, 7'h61);
    acc(TDP_STORE, 32'h0040_3010, 1'h1, 1'h0);
    chk(flags, 7'h40);
    chk(rspPaddr, 32'h1234_5010);
    uPipe.set_high(hiw(32'h0040_2000, 8'h06));
    acc(TDP_LOAD, 32'h0040_2ABC, 1'h1, 1'h0);
    chk(flags, 7'h70);
    chk(rspHit, 1'h0);
  endtask

  // Global entry by random write, inhibits and invalid
  task automatic t_global();
    uPipe.put_entry(1'h1, 4'h7, 32'h0, hiw(32'h0080_0000, 8'h09),
                    low(2'h2, 20'h00011, 3'h0, 3'h5), low(2'h1, 20'h00022, 3'h1, 3'h7));
    uPipe.set_high(hiw(32'h0080_0000, 8'h33));
    acc(TDP_LOAD, 32'h0080_0100, 1'h1, 1'h0);
    chk(flags, 7'h68);
    acc(TDP_FETCH, 32'h0080_1100, 1'h1, 1'h0);
    chk(flags, 7'h64);
    acc(TDP_LOAD, 32'h0080_0100, 1'h0, 1'h0);
    chk(flags, 7'h62);
    acc(TDP_FETCH, 32'h0080_1200, 1'h0, 1'h0);
    chk(rspPaddr, 32'h0002_2200);
  endtask

  // Small and large page address forming
  task automatic t_sizes();
    uPipe.put_entry(1'h0, 4'h5, 32'h0, hiw(32'h00C0_0000, 8'h33),
                    low(2'h0, 20'hFFFFF, 3'h0, 3'h6), low(2'h0, 20'h00001, 3'h1, 3'h6));
    acc(TDP_LOAD, 32'h00C0_03FF, 1'h0, 1'h1);
    chk(rspPaddr, 32'h3FFF_FFFF);
    acc(TDP_LOAD, 32'h00C0_0404, 1'h0, 1'h1);
    chk(rspPaddr, 32'h0000_0404);
    uPipe.put_entry(1'h0, 4'h6, 32'h0000_7800, hiw(32'h0100_0000, 8'h33),
                    low(2'h0, 20'hA5A5A, 3'h3, 3'h6), low(2'h0, 20'h5A5A5, 3'h3, 3'h6));
    acc(TDP_LOAD, 32'h0100_3FFC, 1'h0, 1'h0);
    chk(rspPaddr, 32'hA5A5_BFFC);
    acc(TDP_STORE, 32'h0100_6000, 1'h0, 1'h0);
    chk(rspPaddr, 32'h5A5A_6000);
  endtask

  // Every cacheability code through one entry
  task automatic t_cattr();
    for (int c = 0; c < 8; c++) begin
      uPipe.put_entry(1'h0, 4'h2, 32'h0, hiw(32'h0200_0000, 8'h33),
                      low(2'h0, 20'h00100, c[2:0], 3'h6), low(2'h0, 20'h00200, 3'h0, 3'h6));
      acc(TDP_LOAD, 32'h0200_0000, 1'h0, 1'h0);
      chk(rspCacheAttr, (c == 7) ? 3'h2 : (c > 3) ? 3'h3 : c[2:0]);
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d, checks %0d", nMismatch, testsRun);
    if (nMismatch == 0 && testsRun > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Reset, then the scenarios in turn
  initial begin
    {core_clk, rst, smallPageEnable, inhibitExcEnable, accessValid} = 5'h08;
    accessKind = TDP_LOAD;
    accessVaddr = 32'h0;
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    t_pair();
    t_global();
    t_sizes();
    t_cattr();
    report_and_stop();
  end
endmodule
